// ==== src/vid_stepper_regs.svh ====
// Constants of the identification-code reference stepper
`ifndef VID_STEPPER_REGS_SVH
`define VID_STEPPER_REGS_SVH

`define CODE_W 6
`define LEVEL_W 8
`define SYNC_STAGES 3

// Timebase: clock period and switching period in ns
`define MCLK_PERIOD_NS 4
`define SW_PERIOD_NS 2000
`define TICKS_PER_CYCLE 6
// Longest tick spacing, rounded down to whole clocks
`define TICK_CYCLES ((`SW_PERIOD_NS / `MCLK_PERIOD_NS) / `TICKS_PER_CYCLE)
`define TICK_CNT_W 7

// Half a switching cycle and the two-cycle shutdown delay, in ticks
`define HALF_CYCLE_TICKS 4'h3
`define OFF_DELAY_TICKS 4'hc
`define WAIT_CNT_W 4

// Decode: level in 12.5 mV units is base minus code
`define CODE_SPLIT 6'h14
`define LVL_BASE_LO 8'h57
`define LVL_BASE_HI 8'h95
`define LVL_MIN 8'h43
`define LVL_MAX 8'h80
`define OFF_CODE_TOP 5'h1f
`define LVL_STEP 8'h01

`endif

// ==== src/vid_stepper_pkg.sv ====
// Types of the identification-code reference stepper
`default_nettype none
`include "vid_stepper_regs.svh"
package vid_stepper_pkg;
  typedef logic [`CODE_W-1:0] code_t;
  typedef logic [`LEVEL_W-1:0] level_t;
  typedef enum logic [2:0] {
    st_init, st_idle, st_wait, st_slew, st_off_dly, st_shut
  } step_state_t;
endpackage
`default_nettype wire

// ==== src/vid_reference_stepper.sv ====
// Reference level stepper driven by the six-bit identification code
//
// What this block does
// RULE1: Map all 64 codes to table levels 0.8375V..1.600V; two top codes mean off.
// RULE2: Sample identification inputs six times each switching cycle, detecting code changes.
// RULE3: After a change wait half a cycle, then step reference 12.5mV toward target.
// RULE4: If the difference sign reverses during the wait, make no step.
// RULE5: With more than one step to go, step six times per cycle until equal.
// RULE6: Processor should change the code one step at a time, at controlled rate.
// RULE7: Off code shuts down after two cycles; any other code then starts soft start.
// RULE8: Identification inputs form one six-bit code selecting one discrete level.
// RULE9: Six evenly spaced ticks per switching cycle time sampling, waits and steps.
`timescale 1ns/1ps
`default_nettype none
`include "vid_stepper_regs.svh"

module vid_reference_stepper (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Identification code pins from the processor
  input wire logic id_code_bit4,
  input wire logic id_code_bit3,
  input wire logic id_code_bit2,
  input wire logic id_code_bit1,
  input wire logic id_code_bit0,
  input wire logic id_code_half_step_bit,
  // Reference and control outputs
  output var vid_stepper_pkg::level_t reference_level,
  output logic pwm_enable,
  output logic ov_shutdown_level,
  output logic soft_start_req
);
  import vid_stepper_pkg::*;

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  code_t pins;
  logic [`CODE_W-1:0] s1_q, s2_q, s3_q;
  code_t code_q, code_d;

  assign pins = {id_code_bit4, id_code_bit3, id_code_bit2,
                 id_code_bit1, id_code_bit0, id_code_half_step_bit};

  // A bit counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < `CODE_W; gi++) begin : g_bit
      always_comb begin
        code_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : code_q[gi]; // RULE8
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
      code_q <= 6'h00;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      code_q <= code_d;
    end
  end

  // ************************************************************
  // Tick timebase
  // ************************************************************
  logic [`TICK_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    if (tick_cnt_q == `TICK_CNT_W'(`TICK_CYCLES - 1)) begin // RULE9
      tick_cnt_d = 7'h00;
      tick_d = 1'b1;
    end else begin
      tick_cnt_d = tick_cnt_q + 7'h01;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
    end
  end

  // ************************************************************
  // Code decode
  // ************************************************************
  function automatic level_t decode(input code_t c);
    if (c <= `CODE_SPLIT) begin
      decode = `LVL_BASE_LO - {2'b00, c}; // RULE1
    end else begin
      decode = `LVL_BASE_HI - {2'b00, c}; // RULE1
    end
  endfunction

  level_t target;
  logic is_off;
  assign target = decode(code_q);
  assign is_off = (code_q[5:1] == `OFF_CODE_TOP); // RULE1

  // ************************************************************
  // Stepping state machine
  // ************************************************************
  step_state_t state_q, state_d;
  level_t level_q, level_d;
  code_t seen_q, seen_d;
  logic dir_up_q, dir_up_d;
  logic [`WAIT_CNT_W-1:0] cnt_q, cnt_d;
  logic pwm_q, pwm_d;
  logic ovs_q, ovs_d;
  logic ss_q, ss_d;
  logic tgt_up;
  level_t stepped;

  assign tgt_up = target > level_q;
  assign stepped = dir_up_q ? level_q + `LVL_STEP : level_q - `LVL_STEP;

  always_comb begin
    state_d = state_q;
    level_d = level_q;
    seen_d = seen_q;
    dir_up_d = dir_up_q;
    cnt_d = cnt_q;
    pwm_d = pwm_q;
    ovs_d = ovs_q;
    ss_d = 1'b0;
    if (tick_q) begin
      case (state_q)
        st_init: begin
          seen_d = code_q;
          if (is_off) begin
            state_d = st_off_dly; // RULE7
            cnt_d = 4'h0;
          end else begin
            level_d = target;
            pwm_d = 1'b1;
            state_d = st_idle;
          end
        end
        st_idle: begin
          seen_d = code_q; // RULE2
          if (is_off) begin
            state_d = st_off_dly;
            cnt_d = 4'h0;
          end else if (code_q != seen_q || target != level_q) begin
            if (target != level_q) begin
              dir_up_d = tgt_up;
              cnt_d = 4'h0;
              state_d = st_wait; // RULE3
            end
          end
        end
        st_wait: begin
          seen_d = code_q;
          if (is_off) begin
            state_d = st_off_dly;
            cnt_d = 4'h0;
          end else if (cnt_q == `HALF_CYCLE_TICKS - 4'h1) begin
            if (target == level_q) begin
              state_d = st_idle;
            end else if (tgt_up != dir_up_q) begin
              dir_up_d = tgt_up; // RULE4
              cnt_d = 4'h0;
            end else begin
              level_d = stepped; // RULE3
              state_d = (stepped == target) ? st_idle : st_slew;
            end
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        st_slew: begin
          seen_d = code_q;
          if (is_off) begin
            state_d = st_off_dly;
            cnt_d = 4'h0;
          end else if (target == level_q) begin
            state_d = st_idle;
          end else if (tgt_up != dir_up_q) begin
            dir_up_d = tgt_up; // RULE4
            cnt_d = 4'h0;
            state_d = st_wait;
          end else begin
            level_d = stepped; // RULE5
            state_d = (stepped == target) ? st_idle : st_slew;
          end
        end
        st_off_dly: begin
          seen_d = code_q;
          if (!is_off) begin
            state_d = pwm_q ? st_idle : st_init;
          end else if (cnt_q == `OFF_DELAY_TICKS - 4'h1) begin
            pwm_d = 1'b0; // RULE7
            ovs_d = 1'b1; // RULE7
            state_d = st_shut;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        st_shut: begin
          seen_d = code_q;
          if (!is_off) begin
            ss_d = 1'b1; // RULE7
            level_d = target;
            pwm_d = 1'b1;
            ovs_d = 1'b0;
            state_d = st_idle;
          end
        end
        default: state_d = st_init;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= st_init;
      level_q <= 8'h00;
      seen_q <= 6'h00;
      dir_up_q <= 1'b0;
      cnt_q <= 4'h0;
      pwm_q <= 1'b0;
      ovs_q <= 1'b0;
      ss_q <= 1'b0;
    end else begin
      state_q <= state_d;
      level_q <= level_d;
      seen_q <= seen_d;
      dir_up_q <= dir_up_d;
      cnt_q <= cnt_d;
      pwm_q <= pwm_d;
      ovs_q <= ovs_d;
      ss_q <= ss_d;
    end
  end

  assign reference_level = level_q;
  assign pwm_enable = pwm_q;
  assign ov_shutdown_level = ovs_q;
  assign soft_start_req = ss_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_tick_period: assert property (tick_q |-> ##83 tick_q) // RULE9
    else $error("tick spacing wrong");
  a_tick_gap: assert property (tick_q |=> !tick_q [*8]) // RULE2
    else $error("ticks too close");
  a_step_size: assert property ( // RULE5
    ($past(state_q) == st_wait || $past(state_q) == st_slew) &&
    level_q != $past(level_q) |->
    (level_q - $past(level_q) == 8'h01 || $past(level_q) - level_q == 8'h01))
    else $error("step not one unit");
  a_step_on_tick: assert property ( // RULE5
    level_q != $past(level_q) |-> $past(tick_q))
    else $error("level moved off tick");
  a_level_range: assert property ( // RULE1
    pwm_q |-> level_q >= `LVL_MIN && level_q <= `LVL_MAX)
    else $error("level out of range");
  a_wait_hold: assert property ( // RULE3
    state_q == st_wait && cnt_q != `HALF_CYCLE_TICKS - 4'h1 |=>
    $stable(level_q))
    else $error("step during wait");
  a_wait_first: assert property ( // RULE3
    state_q == st_idle && tick_q && !is_off && target != level_q |=>
    state_q == st_wait && $stable(level_q))
    else $error("step without wait");
  a_no_reverse: assert property ( // RULE4
    state_q == st_wait && tick_q && !is_off && target != level_q &&
    tgt_up != dir_up_q |=> state_q == st_wait && $stable(level_q))
    else $error("step against reversed target");
  a_off_shutdown: assert property ( // RULE7
    $rose(ovs_q) |-> $past(state_q) == st_off_dly && !pwm_q)
    else $error("shutdown without delay");
  a_soft_pulse: assert property (ss_q |-> pwm_q ##1 !ss_q) // RULE7
    else $error("soft start not a pulse");

  c_step_up: cover property (state_q == st_slew && dir_up_q && tick_q);
  c_step_down: cover property (state_q == st_slew && !dir_up_q && tick_q);
  c_shutdown: cover property ($rose(ovs_q));
  c_soft_start: cover property (ss_q);
  c_reverse: cover property (state_q == st_wait && tick_q && tgt_up != dir_up_q);
endmodule
`default_nettype wire

// ==== sim/vid_code_host.sv ====
// Processor model that drives the six identification code pins
`timescale 1ns/1ps
`default_nettype none
module vid_code_host #(
  parameter int HOLD = 40
) (
  // Clock
  input wire logic mclk,
  // Requested code and direct jump enable
  input wire logic [5:0] want,
  input wire logic jump,
  // Code pins, always driven
  output logic [5:0] pins
);
  int cnt = 0;
  always @(negedge mclk) begin
    cnt <= (cnt == HOLD) ? 0 : cnt + 1;
    if (jump) begin
      pins <= want;
    end else if (cnt == HOLD && pins != want) begin
      pins <= (pins < want) ? pins + 6'h01 : pins - 6'h01;
    end
  end
endmodule
`default_nettype wire

// ==== sim/vid_reference_stepper_tb_top.sv ====
// Self-checking testbench of the identification-code reference stepper
`timescale 1ns/1ps
`default_nettype none
module vid_reference_stepper_tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] want = 6'h00;
  logic jump = 1'b1;
  logic [5:0] pins;
  logic [7:0] lvl;
  logic pwm;
  logic ovs;
  logic ssr;
  int n_fail = 0;
  int check_count = 0;
  int t;
  logic [13:0] rows [7] = '{{6'h01, 8'h56}, {6'h00, 8'h57}, {6'h14, 8'h43},
    {6'h15, 8'h80}, {6'h3d, 8'h58}, {6'h32, 8'h63}, {6'h00, 8'h57}};

  always #2 mclk = ~mclk;

  vid_code_host vid_code_host_inst (.mclk(mclk), .want(want), .jump(jump),
    .pins(pins));
  vid_reference_stepper vid_reference_stepper_inst (.mclk(mclk),
    .reset(reset), .id_code_bit4(pins[5]), .id_code_bit3(pins[4]),
    .id_code_bit2(pins[3]), .id_code_bit1(pins[2]), .id_code_bit0(pins[1]),
    .id_code_half_step_bit(pins[0]), .reference_level(lvl),
    .pwm_enable(pwm), .ov_shutdown_level(ovs), .soft_start_req(ssr));

  // ****************************************
  // Checking and waiting helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_lvl(input logic [7:0] exp, input int lim);
    t = 0;
    while (lvl !== exp && t < lim) begin
      @(negedge mclk);
      t++;
    end
    chk(lvl, exp);
    if (lvl !== exp) begin
      wrap_up();
    end
  endtask

  task automatic wait_chg(input int lim);
    logic [7:0] old;
    old = lvl;
    t = 0;
    while (lvl === old && t < lim) begin
      @(negedge mclk);
      t++;
    end
    // Level never moved: count it and stop
    if (lvl === old) begin
      chk(lvl, ~old);
      wrap_up();
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(negedge mclk);
    chk({lvl[6:0] | {4'h0, pwm, ovs, ssr}, lvl[7]}, 8'h00);
    reset = 1'b0;
    wait_lvl(8'h57, 100);
    chk({7'h00, pwm}, 8'h01);
    foreach (rows[i]) begin
      want = rows[i][13:8];
      wait_lvl(rows[i][7:0], 5810);
    end
    // Single step latency: detect tick plus half-cycle wait
    want = 6'h01;
    wait_chg(600);
    chk({7'h00, t >= 249 && t <= 340}, 8'h01);
    chk(lvl, 8'h56);
    // Multi-step slew spacing
    want = 6'h05;
    wait_chg(600);
    wait_chg(200);
    chk(t[7:0], 8'h53);
    chk(lvl, 8'h54);
    wait_lvl(8'h52, 400);
    // Direction reverses during the wait: first move must be upward
    want = 6'h06;
    repeat (120) @(negedge mclk);
    want = 6'h03;
    wait_chg(1000);
    chk(lvl, 8'h53);
    wait_lvl(8'h54, 600);
    // Off code, delayed shutdown, then recovery on a valid code
    want = 6'h3e;
    repeat (900) @(negedge mclk);
    chk({6'h00, pwm, ovs}, 8'h02);
    repeat (300) @(negedge mclk);
    chk({6'h00, pwm, ovs}, 8'h01);
    want = 6'h3f;
    repeat (100) @(negedge mclk);
    chk({6'h00, pwm, ovs}, 8'h01);
    want = 6'h00;
    t = 0;
    while (ssr !== 1'b1 && t < 200) begin
      @(negedge mclk);
      t++;
    end
    chk({7'h00, ssr}, 8'h01);
    @(negedge mclk);
    chk({ssr, 5'h00, pwm, ovs}, 8'h02);
    chk(lvl, 8'h57);
    // Processor walks the code one step at a time
    jump = 1'b0;
    want = 6'h03;
    wait_lvl(8'h54, 1500);
    wrap_up();
  end
endmodule
`default_nettype wire
